// ===== design/bmpc_pkg.sv
package bmpc_pkg;

   localparam int unsigned CLK_HZ = 40_000_000;

   // Blanking for burst entry and for overload before auto-restart
   localparam int unsigned BLANK_MS = 24;
   localparam int unsigned BLANK_CYC = BLANK_MS * (CLK_HZ / 1000);
   localparam int unsigned BLANK_W = 20;

   // Fixed-frequency burst timer and its duty limit
   localparam int unsigned BURST_FREQ_HZ = 80_000;
   localparam int unsigned BURST_PERIOD_CYC = CLK_HZ / BURST_FREQ_HZ;
   localparam int unsigned BURST_DUTY_PCT = 50;
   localparam int unsigned BURST_ON_CYC = (BURST_PERIOD_CYC * BURST_DUTY_PCT) / 100;
   localparam int unsigned TMR_W = 9;

   // Output over-voltage blanking on the valley sense pin
   localparam int unsigned OVP_BLANK_NS = 1000;
   localparam int unsigned OVP_BLANK_CYC = (OVP_BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned OVP_W = 7;

   // Valley up/down counter limits
   localparam logic [2:0] UPDOWN_MAX = 3'h7;
   localparam logic [2:0] UPDOWN_MIN = 3'h1;

   // Comparator synchroniser width
   localparam int unsigned CMP_N = 11;

   typedef enum logic [2:0] {
      ST_OFF    = 3'h0,
      ST_RUN    = 3'h1,
      ST_B_IDLE = 3'h3,
      ST_B_SW   = 3'h2,
      ST_LATCH  = 3'h6
   } bmpc_state_t;

endpackage : bmpc_pkg

// ===== design/bmpc_ctrl.sv
`timescale 1ns/1ps

module bmpc_ctrl #(
   parameter int unsigned BLANK_CYC = bmpc_pkg::BLANK_CYC
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic reg_low_cmp,
   input wire logic burst_on_cmp,
   input wire logic burst_off_cmp,
   input wire logic burst_exit_cmp,
   input wire logic burst_ilim_cmp,
   input wire logic cs_trip_cmp,
   input wire logic overload_cmp,
   input wire logic supply_uv_cmp,
   input wire logic supply_ov_cmp,
   input wire logic supply_on_cmp,
   input wire logic out_ovp_cmp,
   input wire logic short_winding_cmp,
   input wire logic [2:0] updown_count,
   input wire logic valley_turn_on,
   output logic gate_drive,
   output logic burst_active,
   output logic burst_ilim_select,
   output logic bias_enable,
   output logic startup_cell_en,
   output logic valley_cmp_disable,
   output logic updown_preset,
   output logic soft_start,
   output logic restart_wait,
   output logic latched_off
);
   import bmpc_pkg::*;

   localparam logic [BLANK_W-1:0] BLANK_LAST = BLANK_W'(BLANK_CYC - 1);
   localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(BURST_PERIOD_CYC - 1);
   localparam logic [TMR_W-1:0] TMR_ON = TMR_W'(BURST_ON_CYC);
   localparam logic [OVP_W-1:0] OVP_LAST = OVP_W'(OVP_BLANK_CYC - 1);

   function automatic logic [BLANK_W-1:0] blank_step(input logic cond, input logic [BLANK_W-1:0] cnt);
      if (!cond) begin
         blank_step = '0;
      end else if (cnt == BLANK_LAST) begin
         blank_step = cnt;
      end else begin
         blank_step = cnt + 1'b1;
      end
   endfunction : blank_step

   function automatic logic in_burst(input bmpc_state_t s);
      in_burst = (s == ST_B_IDLE) || (s == ST_B_SW);
   endfunction : in_burst

   ////////////////////////////////////////////////////////////////////////////
   // Comparator synchronisers

   logic [CMP_N-1:0] cmp_meta;
   logic [CMP_N-1:0] cmp_sync;
   wire [CMP_N-1:0] cmp_raw = {reg_low_cmp, burst_on_cmp, burst_off_cmp, burst_exit_cmp, burst_ilim_cmp,
                               cs_trip_cmp, overload_cmp, supply_uv_cmp, supply_ov_cmp, supply_on_cmp,
                               out_ovp_cmp};
   // Short-winding gets its own pair; it only counts while the gate is high
   logic sw_meta;
   logic sw_sync;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cmp_meta <= '0;
         cmp_sync <= '0;
         sw_meta <= 1'b0;
         sw_sync <= 1'b0;
      end else begin
         cmp_meta <= cmp_raw;
         cmp_sync <= cmp_meta;
         sw_meta <= short_winding_cmp;
         sw_sync <= sw_meta;
      end
   end

   wire reg_low_s = cmp_sync[10];
   wire bon_s = cmp_sync[9];
   wire boff_s = cmp_sync[8];
   wire exit_s = cmp_sync[7];
   wire ilim_s = cmp_sync[6];
   wire cs_s = cmp_sync[5];
   wire ovl_s = cmp_sync[4];
   wire uv_s = cmp_sync[3];
   wire ov_s = cmp_sync[2];
   wire on_s = cmp_sync[1];
   wire ovp_s = cmp_sync[0];
   wire sw_s = sw_sync;

   ////////////////////////////////////////////////////////////////////////////
   // Timers and blanking counters

   bmpc_state_t state;
   bmpc_state_t next_state;
   logic armed;
   logic [BLANK_W-1:0] ent_cnt;
   logic [BLANK_W-1:0] ovl_cnt;
   logic [OVP_W-1:0] ovp_cnt;
   logic [TMR_W-1:0] tmr;

   wire active = (state == ST_RUN) || in_burst(state);
   wire entry_ok = (state == ST_RUN) && reg_low_s && (updown_count == UPDOWN_MAX);
   wire ovl_ok = (state == ST_RUN) && ovl_s;
   wire ovp_ok = active && !gate_drive && ovp_s;
   wire ovp_trip = ovp_ok && (ovp_cnt == OVP_LAST);
   wire sw_trip = active && gate_drive && sw_s;
   wire supply_fault = uv_s || ov_s;
   wire restart_ok = (state == ST_OFF) && armed && on_s && !supply_fault;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ent_cnt <= '0;
         ovl_cnt <= '0;
         ovp_cnt <= '0;
         tmr <= '0;
      end else begin
         ent_cnt <= blank_step(entry_ok, ent_cnt);
         ovl_cnt <= blank_step(ovl_ok, ovl_cnt);
         ovp_cnt <= !ovp_ok ? '0 : (ovp_cnt == OVP_LAST) ? ovp_cnt : ovp_cnt + 1'b1;
         tmr <= (tmr == TMR_LAST) ? '0 : tmr + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Operating state

   always_comb begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (restart_ok) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (ovl_ok && ovl_cnt == BLANK_LAST) begin
               next_state = ST_OFF;
            end else if (entry_ok && ent_cnt == BLANK_LAST) begin
               next_state = ST_B_IDLE;
            end
         end
         ST_B_IDLE: begin
            if (exit_s) begin
               next_state = ST_RUN;
            end else if (bon_s) begin
               next_state = ST_B_SW;
            end
         end
         ST_B_SW: begin
            if (exit_s) begin
               next_state = ST_RUN;
            end else if (boff_s) begin
               next_state = ST_B_IDLE;
            end
         end
         ST_LATCH: begin
            next_state = ST_LATCH;
         end
         default: begin
            next_state = ST_OFF;
         end
      endcase
      if (active && supply_fault) begin
         next_state = ST_OFF;
      end
      if (ovp_trip || sw_trip) begin
         next_state = ST_LATCH;
      end
   end

   // Power-up counts as an under-voltage, so the startup cell charges first
   wire next_armed = uv_s || (armed && !restart_ok);

   ////////////////////////////////////////////////////////////////////////////
   // Gate flip-flop

   wire burst_set = (state == ST_B_SW) && (tmr == '0);
   wire burst_clr = ilim_s || (tmr == TMR_ON);
   wire norm_set = (state == ST_RUN) && valley_turn_on && !valley_cmp_disable;
   wire gate_on_ok = (next_state == ST_RUN) || (next_state == ST_B_SW);
   wire burst_gate = burst_clr ? 1'b0 : (burst_set ? 1'b1 : gate_drive);
   wire norm_gate = cs_s ? 1'b0 : (norm_set ? 1'b1 : gate_drive);
   wire next_gate = gate_on_ok && ((state == ST_B_SW) ? burst_gate : norm_gate);
   wire next_burst = in_burst(next_state);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_OFF;
         armed <= 1'b1;
         gate_drive <= 1'b0;
         burst_active <= 1'b0;
         burst_ilim_select <= 1'b0;
         bias_enable <= 1'b0;
         startup_cell_en <= 1'b1;
         valley_cmp_disable <= 1'b0;
         updown_preset <= 1'b0;
         soft_start <= 1'b0;
         restart_wait <= 1'b1;
         latched_off <= 1'b0;
      end else begin
         state <= next_state;
         armed <= next_armed;
         gate_drive <= next_gate;
         burst_active <= next_burst;
         burst_ilim_select <= next_burst;
         bias_enable <= (next_state == ST_RUN) || (next_state == ST_B_SW);
         startup_cell_en <= next_burst || (next_state == ST_LATCH) || ((next_state == ST_OFF) && next_armed);
         valley_cmp_disable <= next_burst;
         updown_preset <= in_burst(state) && (next_state == ST_RUN);
         soft_start <= (state == ST_OFF) && (next_state == ST_RUN);
         restart_wait <= next_state == ST_OFF;
         latched_off <= next_state == ST_LATCH;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   burst_entry_a: assert property ((state == ST_RUN && next_state == ST_B_IDLE)
      |-> (reg_low_s && updown_count == UPDOWN_MAX && ent_cnt == BLANK_LAST))
      else $error("burst entered without held entry conditions");
   burst_flag_a: assert property ($rose(burst_active)
      |-> ($past(state) == ST_RUN && state == ST_B_IDLE))
      else $error("burst flag set outside entry");
   burst_resume_a: assert property ((state == ST_B_IDLE && bon_s && !exit_s
      && !supply_fault && !ovp_trip) |=> (state == ST_B_SW && bias_enable))
      else $error("burst switching not resumed");
   burst_turnon_a: assert property (($rose(gate_drive) && state == ST_B_SW) |-> tmr == 9'h001)
      else $error("burst turn-on not from timer");
   timer_set_a: assert property ((state == ST_B_SW && next_state == ST_B_SW
      && tmr == '0 && !ilim_s) |=> gate_drive)
      else $error("burst timer did not start a pulse");
   burst_ilim_a: assert property ((state == ST_B_SW && next_state == ST_B_SW && ilim_s)
      |=> !gate_drive)
      else $error("burst current limit did not end pulse");
   duty_limit_a: assert property ((gate_drive && state == ST_B_SW)
      |-> (tmr >= 9'h001 && tmr <= TMR_ON))
      else $error("burst on-time beyond half period");
   first_off_a: assert property ((state == ST_B_SW && gate_drive && (ilim_s || tmr == TMR_ON))
      |=> !gate_drive)
      else $error("gate not cleared by first turn-off source");
   burst_stop_a: assert property ((state == ST_B_SW && boff_s && !exit_s
      && !supply_fault && !ovp_trip && !sw_trip) |=> (state == ST_B_IDLE && !bias_enable && !gate_drive))
      else $error("burst-off did not pause switching");
   burst_exit_a: assert property ((in_burst(state) && exit_s
      && !supply_fault && !ovp_trip && !sw_trip) |=> (!burst_ilim_select && updown_preset) ##1 !updown_preset)
      else $error("burst exit or counter preset wrong");
   cell_burst_a: assert property ((in_burst(state) || state == ST_LATCH) |-> startup_cell_en)
      else $error("startup cell off in burst or latch");
   supply_fault_a: assert property ((active && supply_fault && !ovp_trip && !sw_trip)
      |=> (state == ST_OFF && !gate_drive && !bias_enable))
      else $error("supply fault did not stop switching");
   restart_a: assert property ((state == ST_OFF && $past(state) == ST_OFF) |-> !gate_drive)
      else $error("switch driven while waiting restart");
   cell_uv_a: assert property ((state == ST_OFF && uv_s) |=> startup_cell_en)
      else $error("startup cell off after under-voltage");
   soft_start_a: assert property (restart_ok |=> (state == ST_RUN && soft_start) ##1 !soft_start)
      else $error("restart without soft-start pulse");
   overload_a: assert property ((state == ST_RUN && next_state == ST_OFF && !supply_fault)
      |-> ovl_cnt == BLANK_LAST)
      else $error("auto-restart before overload blanking");
   ovp_latch_a: assert property (ovp_ok [*8] ##1 ovp_trip |=> (latched_off && !gate_drive))
      else $error("over-voltage did not latch off");
   ovp_early_a: assert property ($rose(ovp_ok) |-> (!ovp_trip) [*8])
      else $error("over-voltage latch before blanking");
   sw_latch_a: assert property (sw_trip |=> (latched_off && !gate_drive))
      else $error("short winding did not latch off");
   latch_cell_a: assert property (latched_off
      |-> (startup_cell_en && !gate_drive && !bias_enable))
      else $error("startup cell off or switch on while latched");
   latch_hold_a: assert property (state == ST_LATCH |=> (state == ST_LATCH && startup_cell_en))
      else $error("latched-off state left without reset");
   valley_off_a: assert property ((burst_active && valley_turn_on && tmr != '0)
      |=> !$rose(gate_drive))
      else $error("valley turn-on acted in burst");
   sync_a: assert property (bon_s == $past(burst_on_cmp, 2))
      else $error("comparator not synchronised");

endmodule : bmpc_ctrl

// ===== tb/bmpc_plant.sv
`timescale 1ns/1ps
// Power switch, shunt and auxiliary winding as the controller sees them
module bmpc_plant (
   input wire logic core_clk,
   input wire logic gate_drive,
   input wire integer ramp,
   input wire logic ovp_fault,
   input wire logic sw_fault,
   output logic burst_ilim_cmp,
   output logic out_ovp_cmp,
   output logic short_winding_cmp
);
   int on_cyc = 0;
   always @(posedge core_clk) begin
      on_cyc <= gate_drive ? on_cyc + 1 : 0;
   end
   // Shunt voltage ramps only while the switch conducts; ramp sets the slope
   assign burst_ilim_cmp = gate_drive && on_cyc >= ramp;
   // Winding faults only show in the phase where the real hardware sees them
   assign out_ovp_cmp = ovp_fault && !gate_drive;
   assign short_winding_cmp = sw_fault && gate_drive;
endmodule : bmpc_plant

// ===== tb/burst_mode_and_protection_ctrl_test.sv
`timescale 1ns/1ps
module burst_mode_and_protection_ctrl_test;
   import bmpc_pkg::*;
   // Short blanking keeps the run brief
   localparam int BL = 20;
   logic core_clk = 0, nrst = 0, reg_low_cmp = 0, burst_on_cmp = 0, burst_off_cmp = 0;
   logic burst_exit_cmp = 0, cs_trip_cmp = 0, overload_cmp = 0, supply_uv_cmp = 0;
   logic supply_ov_cmp = 0, supply_on_cmp = 0, valley_turn_on = 0, ovp_fault = 0, sw_fault = 0;
   logic [2:0] updown_count = 3'h1;
   logic burst_ilim_cmp, out_ovp_cmp, short_winding_cmp, gate_drive, burst_active;
   logic burst_ilim_select, bias_enable, startup_cell_en, valley_cmp_disable;
   logic updown_preset, soft_start, restart_wait, latched_off;
   int ramp = 1000, failures = 0, n_tests = 0, cyc = 0, d, i;
   bmpc_ctrl #(.BLANK_CYC(BL)) uut (.core_clk, .nrst, .reg_low_cmp, .burst_on_cmp, .burst_off_cmp,
      .burst_exit_cmp, .burst_ilim_cmp, .cs_trip_cmp, .overload_cmp, .supply_uv_cmp, .supply_ov_cmp,
      .supply_on_cmp, .out_ovp_cmp, .short_winding_cmp, .updown_count, .valley_turn_on, .gate_drive,
      .burst_active, .burst_ilim_select, .bias_enable, .startup_cell_en, .valley_cmp_disable,
      .updown_preset, .soft_start, .restart_wait, .latched_off);
   bmpc_plant plant (.core_clk, .gate_drive, .ramp, .ovp_fault, .sw_fault, .burst_ilim_cmp,
      .out_ovp_cmp, .short_winding_cmp);
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic chk_n(input string nm, input int exp, input int got);
      n_tests++;
      if (got != exp) begin
         failures++;
         $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
      end
   endtask : chk_n
   task automatic summarize;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : summarize
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask : tick
   // Whichever turn-off source comes first ends the on-pulse
   function automatic int exp_on(input int r);
      return (r + 3 < int'(BURST_ON_CYC)) ? r + 3 : int'(BURST_ON_CYC);
   endfunction : exp_on
   task automatic restart;
      supply_on_cmp = 1;
      tick(3);
      chk("start outs", 10'h6, {soft_start, bias_enable, startup_cell_en});
      tick(1);
      chk("soft_start", 0, soft_start);
      supply_on_cmp = 0;
   endtask : restart
   task automatic pulse(input int r);
      int n;
      n = 0;
      i = 0;
      while (gate_drive === 1 && i < 600) begin
         tick(1);
         i++;
      end
      ramp = r;
      while (gate_drive !== 1 && i < 1200) begin
         tick(1);
         i++;
      end
      while (gate_drive === 1 && n < 600) begin
         tick(1);
         n++;
      end
      chk_n("on cycles", exp_on(r), n);
   endtask : pulse
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      d = $urandom(22557);
      tick(3);
      nrst = 1;
      chk("reset outs", 10'h6, {gate_drive, burst_active, bias_enable, startup_cell_en, restart_wait, latched_off});
      restart();
      reg_low_cmp = 1;
      updown_count = 3'h6;
      tick(BL + 10);
      chk("burst_active", 0, burst_active);
      updown_count = 3'h7;
      // Entry lands on the BL-th edge after the counter reaches seven
      tick(BL - 1);
      chk("burst_active", 0, burst_active);
      tick(1);
      chk("burst outs", 10'h3C, {burst_active, burst_ilim_select, valley_cmp_disable, startup_cell_en, bias_enable, gate_drive});
      for (i = 0; i < 40; i++) begin
         valley_turn_on = 1'($urandom);
         tick(1);
         chk("gate idle", 0, gate_drive);
      end
      valley_turn_on = 0;
      burst_on_cmp = 1;
      tick(4);
      chk("bias_enable", 1, bias_enable);
      pulse(5 + $urandom % 100);
      pulse(120 + $urandom % 120);
      pulse(int'(BURST_ON_CYC));
      pulse(400);
      burst_on_cmp = 0;
      burst_off_cmp = 1;
      tick(4);
      chk("off outs", 10'h0, {bias_enable, gate_drive});
      burst_off_cmp = 0;
      d = 0;
      repeat (600) begin
         tick(1);
         d += (gate_drive !== 0);
      end
      chk_n("idle gate cycles", 0, d);
      reg_low_cmp = 0;
      updown_count = 3'h3;
      burst_exit_cmp = 1;
      tick(3);
      chk("exit outs", 10'h1, {burst_active, burst_ilim_select, valley_cmp_disable, updown_preset});
      tick(1);
      chk("updown_preset", 0, updown_preset);
      burst_exit_cmp = 0;
      overload_cmp = 1;
      tick(BL);
      chk("restart_wait", 0, restart_wait);
      tick(6);
      chk("restart_wait", 1, restart_wait);
      overload_cmp = 0;
      for (d = 0; d < 3; d++) begin
         if (d > 0) begin
            valley_turn_on = 1;
            tick(1);
            valley_turn_on = 0;
            {supply_ov_cmp, supply_uv_cmp} = (d == 1) ? 2'h1 : 2'h2;
            tick(4);
            chk("fault outs", 10'h1, {gate_drive, bias_enable, restart_wait});
         end
         {supply_ov_cmp, supply_uv_cmp} = 2'h1;
         tick(4);
         chk("startup_cell_en", 1, startup_cell_en);
         supply_uv_cmp = 0;
         tick(3);
         restart();
      end
      ovp_fault = 1;
      tick(30);
      chk("latched_off", 0, latched_off);
      tick(20);
      chk("latch outs", 10'h5, {latched_off, gate_drive, startup_cell_en});
      ovp_fault = 0;
      supply_uv_cmp = 1;
      tick(5);
      supply_uv_cmp = 0;
      supply_on_cmp = 1;
      tick(10);
      chk("latched_off", 1, latched_off);
      supply_on_cmp = 0;
      nrst = 0;
      tick(1);
      nrst = 1;
      chk("latched_off", 0, latched_off);
      restart();
      sw_fault = 1;
      tick(5);
      chk("latched_off", 0, latched_off);
      valley_turn_on = 1;
      tick(1);
      valley_turn_on = 0;
      tick(4);
      chk("latched_off", 1, latched_off);
      summarize();
   end
endmodule : burst_mode_and_protection_ctrl_test
